// ===== design/pscr_pkg.sv
package pscr_pkg;

    // --------------------------------------------------------------------
    // Command and response codes
    // --------------------------------------------------------------------
    localparam logic [7:0] PSCR_CMD_PKG_STATUS = 8'h1b;
    localparam logic [7:0] PSCR_CMD_CAPS       = 8'h25;
    localparam logic [7:0] PSCR_RSP_PKG_STATUS = 8'h9b;
    localparam logic [7:0] PSCR_RSP_CAPS       = 8'ha5;
    localparam logic [4:0] PSCR_PKG_CHANNEL    = 5'h1f;

    // Generic response and reason codes
    localparam logic [15:0] PSCR_RC_COMPLETED   = 16'h0000;
    localparam logic [15:0] PSCR_RC_FAILED      = 16'h0001;
    localparam logic [15:0] PSCR_RC_UNAVAILABLE = 16'h0002;
    localparam logic [15:0] PSCR_RC_UNSUPPORTED = 16'h0003;
    localparam logic [15:0] PSCR_RS_NONE        = 16'h0000;
    localparam logic [15:0] PSCR_RS_BAD_LENGTH  = 16'h0005;
    localparam logic [15:0] PSCR_RS_UNKNOWN_CMD = 16'h7fff;

    // --------------------------------------------------------------------
    // Payload layout (word index after header; byte order MSB first)
    // --------------------------------------------------------------------
    localparam logic [2:0] PSCR_STATUS_WORDS = 3'd2;
    localparam logic [2:0] PSCR_CAPS_WORDS   = 3'd7;
    localparam int         PSCR_ARB_BIT      = 0;
    localparam int         PSCR_FAB_W        = 3;
    localparam logic [1:0] PSCR_LAST_BYTE    = 2'd3;

    // --------------------------------------------------------------------
    // Wishbone register map (byte addresses)
    // --------------------------------------------------------------------
    localparam logic [7:0] PSCR_REG_CTRL    = 8'h00;
    localparam logic [7:0] PSCR_REG_COUNTS  = 8'h04;
    localparam logic [7:0] PSCR_REG_MAXES   = 8'h08;
    localparam logic [7:0] PSCR_REG_FABRICS = 8'h0c;
    localparam logic [7:0] PSCR_REG_STATUS  = 8'h10;
    localparam logic [31:0] PSCR_DEF_MAXES  = 32'h01010101;
    localparam logic [31:0] PSCR_DEF_COUNTS = 32'h01010100;
    localparam logic [7:0]  PSCR_DEF_FAB    = 8'h01;

    typedef struct packed {
        logic       valid;
        logic [7:0] cmd_type;
        logic [2:0] package_id;
        logic [4:0] channel;
        logic       chk_ok;
        logic       len_ok;
    } pscr_cmd_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
    } pscr_byte_t;

endpackage

// ===== design/pscr_responder.sv
`timescale 1ns/1ps
// What this block does
// - Commands 0x1B accepted only when internal channel is 0x1F and package matches.
// - Error-free package status query answered with type 0x9B, codes, status word.
// - Only generic response and reason codes are ever returned.
// - Status bit 0 is one only when arbitration is supported and active.
// - Error-free capability query answered with type 0xA5 and full payload.
// - Payload carries 8-bit maximum port count.
// - Payload carries 8-bit configured port count.
// - Payload carries 8-bit maximum host bus count.
// - Payload carries 8-bit configured host bus count.
// - Payload carries 8-bit maximum physical function count.
// - Payload carries 8-bit configured physical function count.
// - Payload carries 8-bit maximum virtual function count.
// - Supported fabrics bitmap uses bits 0..2, upper bits reserved.
// - Enabled fabrics bitmap uses same positions, set only when enabled.
// - A 32-bit other-capabilities word follows, all bits reserved.
module pscr_responder
    import pscr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Parsed command from the header/checksum front end
    input  wire pscr_cmd_t   cmd_i,
    input  wire logic [2:0]  my_package_id_i,
    input  wire logic        arb_supported_i,
    input  wire logic        arb_active_i,
    output pscr_cmd_t        cmd_busy_o,
    output logic             cmd_ready_o,
    // Response stream to the framer (header, checksum, pad added there)
    output pscr_byte_t       rsp_o,
    output logic [7:0]       rsp_type_o,
    output logic             rsp_start_o,
    input  wire logic        rsp_ready_i,
    // Classic Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o
);

    // Idle waits for a command; send walks the payload pointer
    typedef enum logic [1:0] {PSCR_IDLE, PSCR_SEND} pscr_state_t;

    // --------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------
    // Byte-lane merge for partial writes
    function automatic logic [31:0] pscr_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] pscr_fab_word(input logic [31:0] v);
        return {24'h000000, 5'h00, v[PSCR_FAB_W-1:0]};
    endfunction

    // --------------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------------
    pscr_state_t  state_q;
    logic [31:0]  maxes_q;     // max ports, max busses, max PFs, max VFs
    logic [31:0]  counts_q;    // en ports, en busses, en PFs, spare
    logic [31:0]  fabrics_q;   // [7:0] supported, [15:8] enabled
    logic         enable_q;
    logic [15:0]  served_q;
    logic [15:0]  rejected_q;
    logic [2:0]   word_q;
    logic [1:0]   byte_q;
    logic [2:0]   nwords_q;
    logic [31:0]  rc_word_q;
    logic         is_caps_q;
    logic         arb_s1_q;
    logic         arb_s2_q;
    logic         sup_s1_q;
    logic         sup_s2_q;

    // --------------------------------------------------------------------
    // Command decode
    // --------------------------------------------------------------------
    // Only package-addressed commands for this package are ours
    wire logic addr_pkg  = (cmd_i.channel == PSCR_PKG_CHANNEL) &&
                           (cmd_i.package_id == my_package_id_i);
    wire logic is_status = cmd_i.cmd_type == PSCR_CMD_PKG_STATUS;
    wire logic is_caps   = cmd_i.cmd_type == PSCR_CMD_CAPS;
    // A command arriving while a frame is sent is ignored, not queued
    wire logic take      = (state_q == PSCR_IDLE) && cmd_i.valid && cmd_i.chk_ok &&
                           addr_pkg && (is_status || is_caps);
    // Channel-addressed capability queries are not ours; a front end drops them
    wire logic ok_cmd    = enable_q && cmd_i.len_ok;
    // Generic codes only: no command-specific reason exists
    wire logic [31:0] rc_d = !enable_q      ? {PSCR_RC_UNAVAILABLE, PSCR_RS_NONE} :
                             !cmd_i.len_ok  ? {PSCR_RC_FAILED, PSCR_RS_BAD_LENGTH} :
                                              {PSCR_RC_COMPLETED, PSCR_RS_NONE};

    // Arbitration inputs come from pins, so synchronise them
    wire logic   arb_bit     = sup_s2_q && arb_s2_q;
    wire logic [31:0] status_word = {31'h00000000, arb_bit};

    // Fabric bitmaps; an enabled fabric that is not supported is never reported
    wire logic [31:0] sup_fab_w = pscr_fab_word(fabrics_q);
    wire logic [31:0] en_fab_w  = pscr_fab_word(fabrics_q >> 8) & sup_fab_w;

    // --------------------------------------------------------------------
    // Payload word selection
    // --------------------------------------------------------------------
    logic [31:0] cur_word;
    always_comb begin
        cur_word = 32'h00000000;
        case (word_q)
            3'd0: cur_word = rc_word_q;
            3'd1: cur_word = is_caps_q ? {maxes_q[31:24], counts_q[31:24],
                                          maxes_q[23:16], counts_q[23:16]}
                                       : status_word;
            3'd2: cur_word = {maxes_q[15:8], counts_q[15:8],
                              maxes_q[7:0], 8'h00};
            3'd3: cur_word = {sup_fab_w[7:0], en_fab_w[7:0],
                              16'h0000};
            default: cur_word = 32'h00000000; // Other caps low half and reserved words
        endcase
    end

    // Byte 0 of a word goes out first and is its most significant byte
    wire logic [7:0] cur_byte  = cur_word[(PSCR_LAST_BYTE - byte_q)*8 +: 8];
    // A failed command has a single code word, so its frame ends after it
    wire logic       last_word = (word_q == nwords_q - 3'd1);
    wire logic       last_byte = last_word && (byte_q == PSCR_LAST_BYTE);
    // A byte counts as sent only once it has stood on rsp_o with ready high;
    // the pointer moves when the next byte is loaded, so a stall skips nothing
    wire logic       done_byte = rsp_o.valid && rsp_o.last && rsp_ready_i;
    wire logic       load_byte = (state_q == PSCR_SEND) && !done_byte &&
                                 (!rsp_o.valid || rsp_ready_i);

    // --------------------------------------------------------------------
    // Response sequencer
    // --------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q     <= PSCR_IDLE;
            word_q      <= 3'd0;
            byte_q      <= 2'd0;
            nwords_q    <= 3'd0;
            rc_word_q   <= 32'h00000000;
            is_caps_q   <= 1'b0;
            rsp_type_o  <= 8'h00;
            rsp_start_o <= 1'b0;
            cmd_ready_o <= 1'b0;
            cmd_busy_o  <= '0;
        end else begin
            // Start pulse lasts one cycle; the type stays until the next command
            rsp_start_o <= 1'b0;
            // Ready drops in the cycle after a take, with the start pulse and a cycle before the first byte
            cmd_ready_o <= (state_q == PSCR_IDLE) && !take;
            case (state_q)
                PSCR_IDLE: begin
                    if (take) begin
                        state_q     <= PSCR_SEND;
                        cmd_busy_o  <= cmd_i;
                        word_q      <= 3'd0;
                        byte_q      <= 2'd0;
                        rc_word_q   <= rc_d;
                        is_caps_q   <= is_caps;
                        // Failed commands carry only the code word
                        nwords_q    <= !ok_cmd ? 3'd1 :
                                       is_caps ? PSCR_CAPS_WORDS : PSCR_STATUS_WORDS;
                        rsp_type_o  <= is_caps ? PSCR_RSP_CAPS : PSCR_RSP_PKG_STATUS;
                        rsp_start_o <= 1'b1;
                    end
                end
                PSCR_SEND: begin
                    if (load_byte) begin
                        byte_q <= byte_q + 2'd1;
                        if (byte_q == PSCR_LAST_BYTE) begin
                            word_q <= word_q + 3'd1;
                        end
                    end
                    if (done_byte) begin
                        state_q <= PSCR_IDLE;
                    end
                end
                default: state_q <= PSCR_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------------
    // Response byte register
    // --------------------------------------------------------------------
    // Cleared outside a frame so that valid never lingers into idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsp_o <= '0;
        end else if (state_q != PSCR_SEND || done_byte) begin
            rsp_o <= '0;
        end else if (load_byte) begin
            rsp_o.valid <= 1'b1;
            rsp_o.data  <= cur_byte;
            rsp_o.last  <= last_byte;
        end
    end

    // --------------------------------------------------------------------
    // Synchronisers and counters
    // --------------------------------------------------------------------
    // Two stages per pin; the status bit lags its pins by two cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arb_s1_q <= 1'b0;
            arb_s2_q <= 1'b0;
            sup_s1_q <= 1'b0;
            sup_s2_q <= 1'b0;
        end else begin
            arb_s1_q <= arb_active_i;
            arb_s2_q <= arb_s1_q;
            sup_s1_q <= arb_supported_i;
            sup_s2_q <= sup_s1_q;
        end
    end

    // Statistics wrap silently; only their low bytes are visible on the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            served_q   <= 16'h0000;
            rejected_q <= 16'h0000;
        end else if (take) begin
            if (ok_cmd) begin
                served_q <= served_q + 16'h0001;
            end else begin
                rejected_q <= rejected_q + 16'h0001;
            end
        end
    end

    // --------------------------------------------------------------------
    // Wishbone slave: one wait state, error on unmapped address
    // --------------------------------------------------------------------
    wire logic wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire logic hit_ctrl = wb_adr_i == PSCR_REG_CTRL;
    wire logic hit_cnt  = wb_adr_i == PSCR_REG_COUNTS;
    wire logic hit_max  = wb_adr_i == PSCR_REG_MAXES;
    wire logic hit_fab  = wb_adr_i == PSCR_REG_FABRICS;
    wire logic hit_stat = wb_adr_i == PSCR_REG_STATUS;
    wire logic mapped   = hit_ctrl || hit_cnt || hit_max || hit_fab || hit_stat;
    wire logic wr       = wb_req && wb_we_i && mapped;
    // Only bit 0 of the control word is implemented; the other lanes are dropped
    wire logic [31:0] ctrl_merged = pscr_merge({31'h00000000, enable_q}, wb_dat_i, wb_sel_i);

    // Status register is read-only; a write to it is acknowledged and dropped
    wire logic [31:0] rd_mux =
        hit_ctrl ? {31'h00000000, enable_q} :
        hit_cnt  ? counts_q :
        hit_max  ? maxes_q :
        hit_fab  ? {16'h0000, 5'h00, fabrics_q[10:8], 5'h00, fabrics_q[2:0]} :
        hit_stat ? {served_q[7:0], rejected_q[7:0], 12'h000, state_q == PSCR_SEND,
                    sup_s2_q, arb_s2_q, arb_bit} :
                   32'h00000000;

    // Registered ack gives one wait state; a write lands at the request edge
    // and the raised ack blocks a second take only for the one cycle that it is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o  <= 1'b0;
            wb_err_o  <= 1'b0;
            wb_dat_o  <= 32'h00000000;
            enable_q  <= 1'b1;
            maxes_q   <= PSCR_DEF_MAXES;
            counts_q  <= PSCR_DEF_COUNTS;
            fabrics_q <= {16'h0000, PSCR_DEF_FAB, PSCR_DEF_FAB};
        end else begin
            wb_ack_o <= wb_req && mapped;
            wb_err_o <= wb_req && !mapped;
            wb_dat_o <= (wb_req && !wb_we_i) ? rd_mux : 32'h00000000;
            if (wr && hit_ctrl) begin
                enable_q <= ctrl_merged[0];
            end
            // The spare low byte of the counts word stays zero
            if (wr && hit_cnt) begin
                counts_q <= pscr_merge(counts_q, wb_dat_i, wb_sel_i) & 32'hffffff00;
            end
            if (wr && hit_max) begin
                maxes_q <= pscr_merge(maxes_q, wb_dat_i, wb_sel_i);
            end
            // Only the defined fabric bits are stored
            if (wr && hit_fab) begin
                fabrics_q <= pscr_merge(fabrics_q, wb_dat_i, wb_sel_i) & 32'h00000707;
            end
        end
    end

endmodule // pscr_responder

// ===== test/pscr_monitor.sv
`timescale 1ns/1ps
module pscr_monitor
    import pscr_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire pscr_cmd_t  cmd_i,
    input wire logic [2:0] my_package_id_i,
    input wire logic       cmd_ready_o,
    input wire pscr_byte_t rsp_o,
    input wire logic [7:0] rsp_type_o,
    input wire logic       rsp_start_o,
    input wire logic       rsp_ready_i
);
    logic [4:0] idx_q;
    wire logic hit = cmd_ready_o && cmd_i.valid && cmd_i.chk_ok
        && cmd_i.channel == PSCR_PKG_CHANNEL && cmd_i.package_id == my_package_id_i;
    wire logic st  = rsp_o.valid && rsp_type_o == PSCR_RSP_PKG_STATUS;
    wire logic cap = rsp_o.valid && rsp_type_o == PSCR_RSP_CAPS;

    // Index follows accepted bytes only, so a stalled byte keeps its slot
    always_ff @(posedge clk_i) begin
        if (rst_i || rsp_start_o) begin
            idx_q <= '0;
        end else if (rsp_o.valid && rsp_ready_i) begin
            idx_q <= idx_q + 5'd1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_take_status: assert property (
        hit && cmd_i.cmd_type == PSCR_CMD_PKG_STATUS
        |=> rsp_start_o && rsp_type_o == PSCR_RSP_PKG_STATUS) else $error("status not taken");
    chk_take_caps: assert property (
        hit && cmd_i.cmd_type == PSCR_CMD_CAPS
        |=> rsp_start_o && rsp_type_o == PSCR_RSP_CAPS) else $error("caps not taken");
    chk_wrong_chan: assert property (
        cmd_ready_o && cmd_i.valid && cmd_i.channel != PSCR_PKG_CHANNEL
        |=> !rsp_start_o) else $error("channel command answered");
    chk_first_byte: assert property (
        rsp_start_o |-> !cmd_ready_o ##1 rsp_o.valid) else $error("no first byte");
    chk_byte_hold: assert property (
        rsp_o.valid && !rsp_ready_i |=> rsp_o.valid && $stable(rsp_o.data))
        else $error("byte lost in stall");
    chk_status_rsvd: assert property (
        st && idx_q > 5'd3 |-> rsp_o.data[7:1] == 7'h0 && (idx_q == 5'd7 || !rsp_o.data[0]))
        else $error("status reserved bit set");
    chk_caps_tail: assert property (
        cap && idx_q > 5'd13 |-> rsp_o.data == 8'h00 && rsp_o.last == (idx_q == 5'd27))
        else $error("caps tail wrong");
    chk_fab_rsvd: assert property (
        cap && idx_q inside {5'd12, 5'd13} |-> rsp_o.data[7:3] == 5'h0)
        else $error("fabric reserved bit set");
endmodule // pscr_monitor

// ===== test/pscr_sink.sv
`timescale 1ns/1ps
module pscr_sink (
    input  wire logic clk_i,
    input  wire logic start_i,
    output logic      ready_o
);
    int wait_cnt = 0;

    initial ready_o = 1'b1;

    // Stalls before the first byte and at random inside a frame
    always @(posedge clk_i) begin
        if (start_i) begin
            wait_cnt = $urandom_range(3);
        end else if (wait_cnt > 0) begin
            wait_cnt = wait_cnt - 1;
        end else if ($urandom_range(3) == 0) begin
            wait_cnt = 1;
        end
        ready_o <= (wait_cnt == 0);
    end
endmodule // pscr_sink

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import pscr_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    pscr_cmd_t   cmd   = '0;
    logic [2:0]  pkg   = 3'h0;
    logic [1:0]  arb   = 2'h0;
    logic [42:0] wbq   = '0;
    pscr_byte_t  rsp;
    logic [7:0]  rtype, eb, exp_b[$], exp_t[$];
    logic        rdy, start, cready, ack, err, lst;
    logic [31:0] rdat, mx, cn, fw;
    int          error_cnt = 0;
    int          compares  = 0;

    initial forever #50 clk_i = ~clk_i;

    pscr_responder i_dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .my_package_id_i(pkg),
        .arb_supported_i(arb[1]), .arb_active_i(arb[0]), .cmd_busy_o(), .cmd_ready_o(cready),
        .rsp_o(rsp), .rsp_type_o(rtype), .rsp_start_o(start), .rsp_ready_i(rdy),
        .wb_cyc_i(wbq[42]), .wb_stb_i(wbq[41]), .wb_we_i(wbq[40]), .wb_adr_i(wbq[39:32]),
        .wb_sel_i(4'hf), .wb_dat_i(wbq[31:0]), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err));
    pscr_sink i_sink (.clk_i(clk_i), .start_i(start), .ready_o(rdy));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic push_word(input logic [31:0] w);
        for (int k = 3; k >= 0; k--) exp_b.push_back(w[k*8 +: 8]);
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic e);
        @(posedge clk_i);
        wbq <= {2'b11, we, a, d};
        // No limit of its own: only the watchdog ends a hung cycle
        do @(posedge clk_i); while (!ack && !err);
        check(err, e);
        if (!we && !e) check(rdat, d);
        wbq[42:41] <= 2'b00;
    endtask

    task automatic send(input logic [7:0] t, input logic [4:0] ch, input logic [2:0] pk,
                        input logic [1:0] ok);
        do @(posedge clk_i); while (cready !== 1'b1);
        cmd <= '{1'b1, t, pk, ch, ok[1], ok[0]};
        @(posedge clk_i);
        cmd.valid <= 1'b0;
        repeat (4) @(posedge clk_i);
        while (exp_b.size() != 0 || cready !== 1'b1) @(posedge clk_i);
        $display("command %h channel %h done", t, ch);
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Output watcher: an unexpected answer meets an inverted note
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rst_i && start) begin
            eb = exp_t.size() ? exp_t.pop_front() : ~rtype;
            check(rtype, eb);
        end
        if (!rst_i && rsp.valid && rdy) begin
            lst = exp_b.size() == 1;
            eb = exp_b.size() ? exp_b.pop_front() : ~rsp.data;
            check(rsp.data, eb);
            check(rsp.last, lst);
        end
    end

    initial begin
        #2000000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hd931c27d));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        pkg <= 3'($urandom);
        wb(1'b0, PSCR_REG_CTRL, 32'h1, 1'b0);
        wb(1'b0, PSCR_REG_COUNTS, PSCR_DEF_COUNTS, 1'b0);
        wb(1'b0, PSCR_REG_MAXES, PSCR_DEF_MAXES, 1'b0);
        wb(1'b0, PSCR_REG_FABRICS, 32'h101, 1'b0);
        wb(1'b0, 8'h40, 32'h0, 1'b1);
        $display("register test done");
        for (int i = 0; i < 4; i++) begin
            arb <= i[1:0];
            repeat (4) @(posedge clk_i);
            exp_t.push_back(PSCR_RSP_PKG_STATUS);
            push_word(32'h0);
            push_word({31'h0, i == 3});
            send(PSCR_CMD_PKG_STATUS, PSCR_PKG_CHANNEL, pkg, 2'b11);
        end
        for (int i = 0; i < 3; i++) begin
            mx = $urandom;
            cn = $urandom;
            fw = $urandom;
            wb(1'b1, PSCR_REG_MAXES, mx, 1'b0);
            wb(1'b1, PSCR_REG_COUNTS, cn, 1'b0);
            wb(1'b1, PSCR_REG_FABRICS, fw, 1'b0);
            exp_t.push_back(PSCR_RSP_CAPS);
            push_word(32'h0);
            push_word({mx[31:24], cn[31:24], mx[23:16], cn[23:16]});
            push_word({mx[15:8], cn[15:8], mx[7:0], 8'h0});
            push_word({5'h0, fw[2:0], 5'h0, fw[10:8] & fw[2:0], 16'h0});
            repeat (3) push_word(32'h0);
            send(PSCR_CMD_CAPS, PSCR_PKG_CHANNEL, pkg, 2'b11);
        end
        exp_t.push_back(PSCR_RSP_CAPS);
        push_word({PSCR_RC_FAILED, PSCR_RS_BAD_LENGTH});
        send(PSCR_CMD_CAPS, PSCR_PKG_CHANNEL, pkg, 2'b10);
        wb(1'b1, PSCR_REG_CTRL, 32'h0, 1'b0);
        exp_t.push_back(PSCR_RSP_PKG_STATUS);
        push_word({PSCR_RC_UNAVAILABLE, PSCR_RS_NONE});
        send(PSCR_CMD_PKG_STATUS, PSCR_PKG_CHANNEL, pkg, 2'b11);
        wb(1'b1, PSCR_REG_CTRL, 32'h1, 1'b0);
        send(PSCR_CMD_PKG_STATUS, 5'h02, pkg, 2'b11);
        send(PSCR_CMD_CAPS, PSCR_PKG_CHANNEL, pkg + 3'h1, 2'b11);
        send(PSCR_CMD_PKG_STATUS, PSCR_PKG_CHANNEL, pkg, 2'b01);
        send(8'h26, PSCR_PKG_CHANNEL, pkg, 2'b11);
        tally_and_finish();
    end
endmodule // tb_top

bind pscr_responder pscr_monitor i_mon (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .cmd_i           (cmd_i),
    .my_package_id_i (my_package_id_i),
    .cmd_ready_o     (cmd_ready_o),
    .rsp_o           (rsp_o),
    .rsp_type_o      (rsp_type_o),
    .rsp_start_o     (rsp_start_o),
    .rsp_ready_i     (rsp_ready_i)
);
